// *** dv/crf_alu_model.sv ***
/* alu status model: adds two words and reports all four flags.
   assumes the bench drives operands at the falling edge. */
`timescale 1ns/1ps
module crf_alu_model
  import crf_pkg::*;
(
  input  wire logic [DATA_W-1:0] op_a,
  input  wire logic [DATA_W-1:0] op_b,
  input  wire logic              go,
  output crf_alu_flags_s         flags
);
  logic [DATA_W:0] sum;
  always_comb begin
    sum = {1'b0, op_a} + {1'b0, op_b};
    flags.c_vld = go;
    flags.c     = sum[DATA_W];
    flags.z_vld = go;
    flags.z     = (sum[DATA_W-1:0] == '0);
    flags.s_vld = go;
    flags.s     = sum[DATA_W-1];
    flags.o_vld = go;
    flags.o     = (op_a[15] == op_b[15]) && (sum[15] != op_a[15]);
  end
endmodule

// *** dv/crf_core_regs_checker.sv ***
/* checker for the register file outputs.
   assumes it is bound to crf_core_regs. */
`timescale 1ns/1ps
module crf_core_regs_checker
  import crf_pkg::*;
(
  input wire logic              mclk,
  input wire logic              reset,
  input wire crf_wr_s           wr16,
  input wire crf_alu_flags_s    alu_flags,
  input wire logic              flag_wr_en,
  input wire logic [FLAG_W-1:0] flag_wr_data,
  input wire logic              pc_wr_en,
  input wire logic [ADDR_W-1:0] pc_wr_data,
  input wire logic              vtb_wr_en,
  input wire logic [ADDR_W-1:0] vtb_wr_data,
  input wire logic [ADDR_W-1:0] program_counter,
  input wire logic [ADDR_W-1:0] vector_table_base,
  input wire logic [FLAG_W-1:0] cpu_flag_word,
  input wire logic [DATA_W-1:0] frame_base_pointer
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire alu_on = !flag_wr_en;
  sequence fb_wr;
    wr16.en && (wr16.sel == CRF_SEL_FB);
  endsequence
  sequence pc_idle;
    !pc_wr_en;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  pc_load_a: assert property (pc_wr_en |=>
    program_counter == $past(pc_wr_data)) else $error("pc load wrong");
  pc_hold_a: assert property (pc_idle |=>
    $stable(program_counter)) else $error("pc moved");
  vtb_load_a: assert property (vtb_wr_en |=>
    vector_table_base == $past(vtb_wr_data)) else $error("vtb wrong");
  flag_write_a: assert property (flag_wr_en |=>
    cpu_flag_word == $past(flag_wr_data)) else $error("flag write lost");
  carry_cap_a: assert property (alu_on && alu_flags.c_vld |=>
    cpu_flag_word[FLG_C] == $past(alu_flags.c)) else $error("carry");
  zero_cap_a: assert property (alu_on && alu_flags.z_vld |=>
    cpu_flag_word[FLG_Z] == $past(alu_flags.z)) else $error("zero");
  sign_cap_a: assert property (alu_on && alu_flags.s_vld |=>
    cpu_flag_word[FLG_S] == $past(alu_flags.s)) else $error("sign");
  ovf_cap_a: assert property (alu_on && alu_flags.o_vld |=>
    cpu_flag_word[FLG_O] == $past(alu_flags.o)) else $error("overflow");
  debug_keep_a: assert property (alu_on |=>
    $stable(cpu_flag_word[FLG_D])) else $error("debug flag moved");
  fb_load_a: assert property (fb_wr |=>
    frame_base_pointer == $past(wr16.data)) else $error("fb wrong");
endmodule
bind crf_core_regs crf_core_regs_checker chk (.mclk, .reset, .wr16,
  .alu_flags, .flag_wr_en, .flag_wr_data, .pc_wr_en, .pc_wr_data,
  .vtb_wr_en, .vtb_wr_data, .program_counter, .vector_table_base,
  .cpu_flag_word, .frame_base_pointer);

// *** dv/tb_cpu_core_register_file.sv ***
/* self-checking bench for crf_core_regs with an alu flag model.
   assumes inputs change at the falling edge of mclk. */
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
module tb_cpu_core_register_file;
  import crf_pkg::*;
  logic mclk = 0, reset = 1, go = 0, flag_wr_en = 0, pc_wr_en = 0;
  logic vtb_wr_en = 0;
  crf_wr_s wr16 = '0;
  crf_wr32_s wr32 = '0;
  crf_sel_e rd_sel_a = CRF_SEL_NONE, rd_sel_b = CRF_SEL_NONE;
  crf_pair_e rd_pair = CRF_PAIR_NONE;
  crf_alu_flags_s alu_flags;
  logic [FLAG_W-1:0] flag_wr_data = '0, cpu_flag_word;
  logic [ADDR_W-1:0] pc_wr_data = '0, vtb_wr_data = '0;
  logic [ADDR_W-1:0] program_counter, vector_table_base;
  logic [DATA_W-1:0] rd_data_a, rd_data_b, frame_base_pointer, op_a = 0;
  logic [DATA_W-1:0] static_base_pointer, active_stack_pointer, op_b = 0;
  logic [31:0] rd_data_pair;
  int err_total = 0, num_checks = 0, cyc = 0;
  always #5 mclk = ~mclk;
  crf_core_regs dut (.mclk, .reset, .wr16, .wr32, .rd_sel_a, .rd_sel_b,
    .rd_pair, .alu_flags, .flag_wr_en, .flag_wr_data, .pc_wr_en, .pc_wr_data,
    .vtb_wr_en, .vtb_wr_data, .rd_data_a, .rd_data_b, .rd_data_pair,
    .program_counter, .vector_table_base, .cpu_flag_word, .frame_base_pointer,
    .static_base_pointer, .active_stack_pointer);
  crf_alu_model alu (.op_a, .op_b, .go, .flags(alu_flags));
  ////////////////////////////////////////////////////////////////////////////
  task automatic w16(crf_sel_e s, logic [15:0] d);
    @(negedge mclk) wr16 = '{1'b1, s, d};
    @(negedge mclk) wr16.en = 1'b0;
  endtask
  task automatic w32(crf_pair_e p, logic [31:0] d);
    @(negedge mclk) wr32 = '{1'b1, p, d};
    @(negedge mclk) wr32.en = 1'b0;
  endtask
  task automatic fw(logic [10:0] d);
    @(negedge mclk) begin flag_wr_en = 1; flag_wr_data = d; end
    @(negedge mclk) flag_wr_en = 0;
  endtask
  task automatic rd(crf_sel_e s, logic [15:0] e);
    @(negedge mclk) begin rd_sel_a = s; rd_sel_b = s; end
    @(negedge mclk) `CHK({rd_data_a, rd_data_b}, {e, e})
  endtask
  task automatic rp(crf_pair_e p, logic [31:0] e);
    @(negedge mclk) rd_pair = p;
    @(negedge mclk) `CHK(rd_data_pair, e)
  endtask
  task automatic alu_op(logic [15:0] a, logic [15:0] b, logic [3:0] e);
    @(negedge mclk) begin op_a = a; op_b = b; go = 1; end
    @(negedge mclk) go = 0;
    `CHK({cpu_flag_word[FLG_O], cpu_flag_word[FLG_S], cpu_flag_word[FLG_Z],
          cpu_flag_word[FLG_C]}, e)
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_words();
    `CHK({program_counter, cpu_flag_word}, 31'h0)
    for (int i = 0; i < 6; i++) w16(crf_sel_e'(i), 16'(16'hA000 + i));
    for (int i = 0; i < 6; i++) rd(crf_sel_e'(i), 16'(16'hA000 + i));
    w16(CRF_SEL_R0H, 16'h00AB);
    w16(CRF_SEL_R0L, 16'h00CD);
    rd(CRF_SEL_R0, 16'hABCD);
    rd(CRF_SEL_R0H, 16'h00AB);
    w16(CRF_SEL_R1L, 16'hFF5A);
    rd(CRF_SEL_R1, 16'hA05A);
    $display("words and bytes done");
  endtask
  task automatic t_pairs();
    w32(CRF_PAIR_DATA_PAIR_LOW_32, 32'h1234_5678);
    rd(CRF_SEL_R2, 16'h1234);
    rd(CRF_SEL_R0, 16'h5678);
    w32(CRF_PAIR_DATA_PAIR_HIGH_32, 32'h9ABC_DEF0);
    rp(CRF_PAIR_DATA_PAIR_HIGH_32, 32'h9ABC_DEF0);
    rd(CRF_SEL_R3, 16'h9ABC);
    w32(CRF_PAIR_ADDR_PAIR_32, 32'h0F0F_F0F0);
    rd(CRF_SEL_A1, 16'h0F0F);
    rp(CRF_PAIR_ADDR_PAIR_32, 32'h0F0F_F0F0);
    rp(CRF_PAIR_NONE, 32'h0);
    $display("pairs done");
  endtask
  task automatic t_bank_stack();
    fw(11'h010);
    w16(CRF_SEL_R0, 16'hBEEF);
    rd(CRF_SEL_R0, 16'hBEEF);
    fw(11'h000);
    rd(CRF_SEL_R0, 16'h5678);
    w16(CRF_SEL_SP, 16'h0100);
    fw(11'h080);
    w16(CRF_SEL_SP, 16'h0200);
    rd(CRF_SEL_SP, 16'h0200);
    `CHK(active_stack_pointer, 16'h0200)
    rd(CRF_SEL_USP, 16'h0100);
    fw(11'h000);
    rd(CRF_SEL_SP, 16'h0100);
    $display("bank and stack done");
  endtask
  task automatic t_bases_flags();
    @(negedge mclk) begin
      pc_wr_en    = 1;
      pc_wr_data  = 20'hFFFFF;
      vtb_wr_data = 20'h0F0F0;
    end
    @(negedge mclk) begin pc_wr_en = 0; vtb_wr_en = 1; end
    @(negedge mclk) begin vtb_wr_en = 0; vtb_wr_data = 20'h80001; end
    `CHK({program_counter, vector_table_base}, 40'hFFFFF_0F0F0)
    @(negedge mclk) vtb_wr_en = 1;
    @(negedge mclk) vtb_wr_en = 0;
    `CHK(vector_table_base, 20'h80001)
    w16(CRF_SEL_FB, 16'h1357);
    `CHK(frame_base_pointer, 16'h1357)
    w16(CRF_SEL_SB, 16'h2468);
    `CHK(static_base_pointer, 16'h2468)
    alu_op(16'h7FFF, 16'h0001, 4'b1100);
    alu_op(16'hFFFF, 16'h0001, 4'b0011);
    alu_op(16'h8000, 16'h0001, 4'b0100);
    alu_op(16'hFFFF, 16'hFFFF, 4'b0101);
    @(negedge mclk) begin go = 1; op_a = 16'h7FFF; flag_wr_en = 1; end
    @(negedge mclk) begin go = 0; flag_wr_en = 0; end
    `CHK(cpu_flag_word, 11'h000)
    $display("bases and flags done");
  endtask
  task automatic t_reset();
    @(negedge mclk) reset = 1;
    @(negedge mclk) reset = 0;
    `CHK({program_counter, vector_table_base, cpu_flag_word}, 51'h0)
    `CHK({frame_base_pointer, static_base_pointer}, 32'h0)
    `CHK({rd_data_pair, active_stack_pointer}, 48'h0)
    rd(CRF_SEL_R0, 16'h0000);
    fw(11'h010);
    rd(CRF_SEL_R0, 16'h0000);
    fw(11'h000);
    $display("mid-run reset done");
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk) reset = 0;
    t_words();
    t_pairs();
    t_bank_stack();
    t_bases_flags();
    t_reset();
    end_sim();
  end
endmodule

// *** verilog/crf_core_regs.sv ***
/*
  cpu core register file: data, address, base, stack, pc and flag words.
  assumes the alu and execution logic on the same clock drive all ports.
*/
// What this block does
// - four 16-bit data registers, readable and writable as operands
// - first two data registers also accessible as separate 8-bit halves
// - third with first, fourth with second, form 32-bit pairs, high upper
// - two 16-bit address registers for addressing and general operations
// - second address register joins first as a 32-bit pair, high upper
// - 16-bit frame base register for frame-relative addressing
// - 20-bit vector table base register
// - 20-bit program counter holds next instruction address
// - user and interrupt stack pointers, stack-select flag picks active one
// - 16-bit static base register
// - 11-bit flag word shows processor state
// - carry flag captures alu carry, borrow or shifted-out bit
// - zero flag set when result is zero, else cleared
// - sign flag set when result negative, else cleared
// - bank flag selects register bank 0 or 1 for data and address sets
// - overflow flag set on overflow, else cleared
`timescale 1ns/1ps
module crf_core_regs
  import crf_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire crf_wr_s              wr16,
  input  wire crf_wr32_s            wr32,
  input  wire crf_sel_e             rd_sel_a,
  input  wire crf_sel_e             rd_sel_b,
  input  wire crf_pair_e            rd_pair,
  input  wire crf_alu_flags_s       alu_flags,
  input  wire logic                 flag_wr_en,
  input  wire logic [FLAG_W-1:0]    flag_wr_data,
  input  wire logic                 pc_wr_en,
  input  wire logic [ADDR_W-1:0]    pc_wr_data,
  input  wire logic                 vtb_wr_en,
  input  wire logic [ADDR_W-1:0]    vtb_wr_data,
  output logic      [DATA_W-1:0]    rd_data_a,
  output logic      [DATA_W-1:0]    rd_data_b,
  output logic      [31:0]          rd_data_pair,
  output logic      [ADDR_W-1:0]    program_counter,
  output logic      [ADDR_W-1:0]    vector_table_base,
  output logic      [FLAG_W-1:0]    cpu_flag_word,
  output logic      [DATA_W-1:0]    frame_base_pointer,
  output logic      [DATA_W-1:0]    static_base_pointer,
  output logic      [DATA_W-1:0]    active_stack_pointer
);

  ////////////////////////////////////////////////////////////////////////////
  // storage: two banks of data and address registers
  logic [DATA_W-1:0] data_r [2][4];
  logic [DATA_W-1:0] addr_r [2][2];
  logic [DATA_W-1:0] usp_r;
  logic [DATA_W-1:0] isp_r;
  logic              bank;
  logic              use_isp;

  assign bank    = cpu_flag_word[FLG_B];
  assign use_isp = cpu_flag_word[FLG_U];

  // words of the active bank, shared by both read ports and the pair port
  logic [DATA_W-1:0] cur_d0;
  logic [DATA_W-1:0] cur_d1;
  logic [DATA_W-1:0] cur_d2;
  logic [DATA_W-1:0] cur_d3;
  logic [DATA_W-1:0] cur_a0;
  logic [DATA_W-1:0] cur_a1;

  always_comb begin
    cur_d0 = data_r[bank][0];
    cur_d1 = data_r[bank][1];
    cur_d2 = data_r[bank][2];
    cur_d3 = data_r[bank][3];
    cur_a0 = addr_r[bank][0];
    cur_a1 = addr_r[bank][1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux for one 16-bit selector
  function automatic logic [DATA_W-1:0] rd16(
    input crf_sel_e           s,
    input logic [DATA_W-1:0]  d0,
    input logic [DATA_W-1:0]  d1,
    input logic [DATA_W-1:0]  d2,
    input logic [DATA_W-1:0]  d3,
    input logic [DATA_W-1:0]  a0,
    input logic [DATA_W-1:0]  a1,
    input logic [DATA_W-1:0]  fb,
    input logic [DATA_W-1:0]  sb,
    input logic [DATA_W-1:0]  us,
    input logic [DATA_W-1:0]  is,
    input logic               u
  );
    logic [DATA_W-1:0] r;
    r = WORD_RST;
    case (s)
      CRF_SEL_R0:  r = d0;
      CRF_SEL_R1:  r = d1;
      CRF_SEL_R2:  r = d2;
      CRF_SEL_R3:  r = d3;
      CRF_SEL_A0:  r = a0;
      CRF_SEL_A1:  r = a1;
      CRF_SEL_FB:  r = fb;
      CRF_SEL_SB:  r = sb;
      CRF_SEL_SP:  r = u ? is : us;
      CRF_SEL_USP: r = us;
      CRF_SEL_ISP: r = is;
      CRF_SEL_R0H: r = {8'h00, d0[DATA_W-1:BYTE_W]};
      CRF_SEL_R0L: r = {8'h00, d0[BYTE_W-1:0]};
      CRF_SEL_R1H: r = {8'h00, d1[DATA_W-1:BYTE_W]};
      CRF_SEL_R1L: r = {8'h00, d1[BYTE_W-1:0]};
      default:     r = WORD_RST;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // data registers of the active bank
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < 4; i++) begin
          data_r[b][i] <= WORD_RST;
        end
      end
    end else begin
      if (wr16.en) begin
        case (wr16.sel)
          CRF_SEL_R0:  data_r[bank][0] <= wr16.data;
          CRF_SEL_R1:  data_r[bank][1] <= wr16.data;
          CRF_SEL_R2:  data_r[bank][2] <= wr16.data;
          CRF_SEL_R3:  data_r[bank][3] <= wr16.data;
          CRF_SEL_R0H: data_r[bank][0][DATA_W-1:BYTE_W] <=
                         wr16.data[BYTE_W-1:0];
          CRF_SEL_R0L: data_r[bank][0][BYTE_W-1:0] <=
                         wr16.data[BYTE_W-1:0];
          CRF_SEL_R1H: data_r[bank][1][DATA_W-1:BYTE_W] <=
                         wr16.data[BYTE_W-1:0];
          CRF_SEL_R1L: data_r[bank][1][BYTE_W-1:0] <=
                         wr16.data[BYTE_W-1:0];
          default: ;
        endcase
      end
      if (wr32.en) begin
        case (wr32.sel)
          CRF_PAIR_DATA_PAIR_LOW_32: begin
            data_r[bank][2] <= wr32.data[31:16];
            data_r[bank][0] <= wr32.data[15:0];
          end
          CRF_PAIR_DATA_PAIR_HIGH_32: begin
            data_r[bank][3] <= wr32.data[31:16];
            data_r[bank][1] <= wr32.data[15:0];
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address registers of the active bank
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int b = 0; b < 2; b++) begin
        addr_r[b][0] <= WORD_RST;
        addr_r[b][1] <= WORD_RST;
      end
    end else begin
      if (wr16.en && wr16.sel == CRF_SEL_A0) begin
        addr_r[bank][0] <= wr16.data;
      end
      if (wr16.en && wr16.sel == CRF_SEL_A1) begin
        addr_r[bank][1] <= wr16.data;
      end
      if (wr32.en && wr32.sel == CRF_PAIR_ADDR_PAIR_32) begin
        addr_r[bank][1] <= wr32.data[31:16];
        addr_r[bank][0] <= wr32.data[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame and static base registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      frame_base_pointer  <= WORD_RST;
      static_base_pointer <= WORD_RST;
    end else if (wr16.en) begin
      case (wr16.sel)
        CRF_SEL_FB: frame_base_pointer  <= wr16.data;
        CRF_SEL_SB: static_base_pointer <= wr16.data;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack pointers; the plain stack code writes the active one
  always_ff @(posedge mclk) begin
    if (reset) begin
      usp_r <= WORD_RST;
      isp_r <= WORD_RST;
    end else if (wr16.en) begin
      case (wr16.sel)
        CRF_SEL_USP: usp_r <= wr16.data;
        CRF_SEL_ISP: isp_r <= wr16.data;
        CRF_SEL_SP: begin
          if (use_isp) begin
            isp_r <= wr16.data;
          end else begin
            usp_r <= wr16.data;
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter and vector table base
  always_ff @(posedge mclk) begin
    if (reset) begin
      program_counter <= ADDR_RST;
    end else if (pc_wr_en) begin
      program_counter <= pc_wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      vector_table_base <= ADDR_RST;
    end else if (vtb_wr_en) begin
      vector_table_base <= vtb_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag word: explicit write wins over alu status
  always_ff @(posedge mclk) begin
    if (reset) begin
      cpu_flag_word <= FLAG_RST;
    end else if (flag_wr_en) begin
      cpu_flag_word <= flag_wr_data;
    end else begin
      if (alu_flags.c_vld) begin
        cpu_flag_word[FLG_C] <= alu_flags.c;
      end
      if (alu_flags.z_vld) begin
        cpu_flag_word[FLG_Z] <= alu_flags.z;
      end
      if (alu_flags.s_vld) begin
        cpu_flag_word[FLG_S] <= alu_flags.s;
      end
      if (alu_flags.o_vld) begin
        cpu_flag_word[FLG_O] <= alu_flags.o;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered read port a, following the active bank and stack select
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_data_a <= WORD_RST;
    end else begin
      rd_data_a <= rd16(rd_sel_a, cur_d0, cur_d1, cur_d2, cur_d3, cur_a0,
                        cur_a1, frame_base_pointer, static_base_pointer,
                        usp_r, isp_r, use_isp);
    end
  end

  // registered read port b, same view as port a
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_data_b <= WORD_RST;
    end else begin
      rd_data_b <= rd16(rd_sel_b, cur_d0, cur_d1, cur_d2, cur_d3, cur_a0,
                        cur_a1, frame_base_pointer, static_base_pointer,
                        usp_r, isp_r, use_isp);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered pair read, upper register in the high half
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_data_pair <= {WORD_RST, WORD_RST};
    end else begin
      case (rd_pair)
        CRF_PAIR_DATA_PAIR_LOW_32: rd_data_pair <= {cur_d2, cur_d0};
        CRF_PAIR_DATA_PAIR_HIGH_32: rd_data_pair <= {cur_d3, cur_d1};
        CRF_PAIR_ADDR_PAIR_32: rd_data_pair <= {cur_a1, cur_a0};
        default:       rd_data_pair <= {WORD_RST, WORD_RST};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active stack pointer view
  always_ff @(posedge mclk) begin
    if (reset) begin
      active_stack_pointer <= WORD_RST;
    end else begin
      active_stack_pointer <= use_isp ? isp_r : usp_r;
    end
  end

endmodule

// *** verilog/crf_pkg.sv ***
/*
  shared constants and carriers for the cpu core register file.
  assumes one system clock and a synchronous active-high reset.
*/
package crf_pkg;

  localparam int DATA_W  = 16;
  localparam int BYTE_W  = 8;
  localparam int ADDR_W  = 20;
  localparam int FLAG_W  = 11;

  // flag word bit positions
  localparam int FLG_C   = 0;
  localparam int FLG_D   = 1;
  localparam int FLG_Z   = 2;
  localparam int FLG_S   = 3;
  localparam int FLG_B   = 4;
  localparam int FLG_O   = 5;
  localparam int FLG_U   = 7;

  localparam logic [FLAG_W-1:0] FLAG_RST = 11'h000;
  localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;

  // register selector codes for read and write ports
  typedef enum logic [3:0] {
    CRF_SEL_R0,
    CRF_SEL_R1,
    CRF_SEL_R2,
    CRF_SEL_R3,
    CRF_SEL_A0,
    CRF_SEL_A1,
    CRF_SEL_FB,
    CRF_SEL_SB,
    CRF_SEL_SP,
    CRF_SEL_USP,
    CRF_SEL_ISP,
    CRF_SEL_R0H,
    CRF_SEL_R0L,
    CRF_SEL_R1H,
    CRF_SEL_R1L,
    CRF_SEL_NONE
  } crf_sel_e;

  // pair selector for 32-bit accesses
  typedef enum logic [1:0] {
    CRF_PAIR_DATA_PAIR_LOW_32,
    CRF_PAIR_DATA_PAIR_HIGH_32,
    CRF_PAIR_ADDR_PAIR_32,
    CRF_PAIR_NONE
  } crf_pair_e;

  // alu status result, each bit with its own valid
  typedef struct packed {
    logic c_vld;
    logic c;
    logic z_vld;
    logic z;
    logic s_vld;
    logic s;
    logic o_vld;
    logic o;
  } crf_alu_flags_s;

  // write request of 16 or 8 bits
  typedef struct packed {
    logic        en;
    crf_sel_e    sel;
    logic [15:0] data;
  } crf_wr_s;

  // write request of 32 bits
  typedef struct packed {
    logic        en;
    crf_pair_e   sel;
    logic [31:0] data;
  } crf_wr32_s;

endpackage
